// ===== rtl/mtsc_regs.svh
`ifndef MTSC_REGS_SVH
`define MTSC_REGS_SVH

// byte offsets of the counter words, most significant byte at the lowest address
`define MTSC_GOOD_BYTE_OFS 12'h30C
`define MTSC_UNDR_ABORT_OFS 12'h334
`define MTSC_TOTAL_ABORT_OFS 12'h338
// interrupt registers, placed just above the counters
`define MTSC_IRQ_STATUS_OFS 12'h340
`define MTSC_IRQ_CLEAR_OFS 12'h344
`define MTSC_IRQ_ENABLE_OFS 12'h348

// interrupt bit positions (counter wrap events)
`define MTSC_IRQ_GOOD_BIT 0
`define MTSC_IRQ_UNDR_BIT 1
`define MTSC_IRQ_TOTAL_BIT 2
`define MTSC_IRQ_W 3

// reset values and the counter maximum
`define MTSC_CNT_RST 32'h0000_0000
`define MTSC_CNT_MAX 32'hFFFF_FFFF
`define MTSC_IRQ_RST 3'h0

`endif

// ===== rtl/mtsc_pkg.sv
package mtsc_pkg;

  // increment pulses from the mac transmit path, one cycle each
  typedef struct packed {
    logic good_byte;
    logic underrun_abort;
    logic abort;
  } mtsc_evt_t;

  // the three counters travel together
  typedef struct packed {
    logic [31:0] good;
    logic [31:0] undr;
    logic [31:0] total;
  } mtsc_cnt_t;

endpackage : mtsc_pkg

// ===== rtl/mtsc_counters.sv
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "mtsc_regs.svh"
// Notes on behaviour
// RL1: count every valid transmitted byte, 32 bits
// RL2: count frames aborted by fifo underrun
// RL3: count every aborted frame, any cause
// RL4: only device reset clears the counters
// RL5: counters wrap to zero, never saturate
// RL6: underrun count at 0334h, msb first
// RL7: total abort count at 0338h, msb first
// RL8: good byte low half at 030Eh-030Fh
// RL9: software keeps intervals below one wrap
// RL10: software differences counts modulo two to 32
// RL11: good byte count starts at 030Ch
// RL12: a read returns one coherent snapshot
module mtsc_counters
  import mtsc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic clk_i, // 125 mhz system clock
  input wire logic rst_i, // synchronous reset, high
  input wire mtsc_evt_t evt_i, // increment pulses
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [ADDR_W-1:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lane selects
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // transfer acknowledge
  output logic irq_o // level interrupt
);

  // word compare on an aligned byte offset
  // address bits 1:0 are ignored, so any byte of a counter selects its whole word
  function automatic logic hit(
    input logic [ADDR_W-1:0] adr,
    input logic [11:0] ofs
  );
    hit = (adr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction : hit

  // wrapping increment, carry out dropped on purpose
  function automatic logic [31:0] bump(
    input logic [31:0] v,
    input logic en
  );
    logic [32:0] s;
    s = {1'b0, v} + {32'h0000_0000, en};
    bump = s[31:0];
  endfunction : bump

  // a wrap happens when an increment meets the all-ones value
  function automatic logic wraps(
    input logic [31:0] v,
    input logic en
  );
    wraps = en && (v == `MTSC_CNT_MAX);
  endfunction : wraps

  // registered state and the next values that feed it
  mtsc_cnt_t cnt_reg;
  mtsc_cnt_t cnt_next;
  logic [`MTSC_IRQ_W-1:0] sts_reg;
  logic [`MTSC_IRQ_W-1:0] sts_next;
  logic [`MTSC_IRQ_W-1:0] ena_reg;
  logic [`MTSC_IRQ_W-1:0] ena_next;
  logic [`MTSC_IRQ_W-1:0] wrap_evt;
  logic [`MTSC_IRQ_W-1:0] clr_mask;
  logic irq_reg;
  logic irq_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  logic req;
  logic wr_stb;
  logic total_inc;

  // a request is taken once; ack_reg blocks a second take
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_stb = req && wb_we_i && wb_sel_i[0];
  // an underrun abort is also an abort, even if the mac forgets to say so
  assign total_inc = evt_i.abort || evt_i.underrun_abort; // RL3

  // counter next values; bus writes never reach them
  always_comb begin
    cnt_next = cnt_reg;
    cnt_next.good = bump(cnt_reg.good, evt_i.good_byte); // RL1 RL5
    cnt_next.undr = bump(cnt_reg.undr, evt_i.underrun_abort); // RL2 RL5
    cnt_next.total = bump(cnt_reg.total, total_inc); // RL3 RL5
  end

  // only reset clears; no bus path exists into this register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '{good: `MTSC_CNT_RST, undr: `MTSC_CNT_RST, total: `MTSC_CNT_RST}; // RL4
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // wrap events feed the sticky status
  always_comb begin
    wrap_evt = '0;
    wrap_evt[`MTSC_IRQ_GOOD_BIT] = wraps(cnt_reg.good, evt_i.good_byte);
    wrap_evt[`MTSC_IRQ_UNDR_BIT] = wraps(cnt_reg.undr, evt_i.underrun_abort);
    wrap_evt[`MTSC_IRQ_TOTAL_BIT] = wraps(cnt_reg.total, total_inc);
  end

  // write-one-to-clear; a wrap in the same cycle wins over the clear
  always_comb begin
    clr_mask = '0;
    if (wr_stb && hit(wb_adr_i, `MTSC_IRQ_CLEAR_OFS)) begin
      clr_mask = wb_dat_i[`MTSC_IRQ_W-1:0];
    end
    sts_next = (sts_reg & ~clr_mask) | wrap_evt;
    ena_next = ena_reg;
    if (wr_stb && hit(wb_adr_i, `MTSC_IRQ_ENABLE_OFS)) begin
      ena_next = wb_dat_i[`MTSC_IRQ_W-1:0];
    end
    // computed from next values so irq_o can come straight off a flop
    irq_next = |(sts_next & ena_next);
  end

  // interrupt state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_reg <= `MTSC_IRQ_RST;
      ena_reg <= `MTSC_IRQ_RST;
      irq_reg <= 1'b0;
    end else begin
      sts_reg <= sts_next;
      ena_reg <= ena_next;
      irq_reg <= irq_next;
    end
  end

  // read mux; the word is latched in one edge so all four bytes agree
  always_comb begin
    ack_next = req;
    dat_next = dat_reg;
    if (req) begin
      dat_next = 32'h0000_0000;
      if (!wb_we_i) begin
        if (hit(wb_adr_i, `MTSC_GOOD_BYTE_OFS)) begin
          dat_next = cnt_reg.good; // RL8 RL11 RL12
        end else if (hit(wb_adr_i, `MTSC_UNDR_ABORT_OFS)) begin
          dat_next = cnt_reg.undr; // RL6 RL12
        end else if (hit(wb_adr_i, `MTSC_TOTAL_ABORT_OFS)) begin
          dat_next = cnt_reg.total; // RL7 RL12
        end else if (hit(wb_adr_i, `MTSC_IRQ_STATUS_OFS)) begin
          dat_next = {29'h0, sts_reg};
        end else if (hit(wb_adr_i, `MTSC_IRQ_ENABLE_OFS)) begin
          dat_next = {29'h0, ena_reg};
        end else begin
          dat_next = 32'h0000_0000;
        end
      end
    end
  end

  // bus answer registers; unmapped words ack with zero data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // every output comes straight off a flop
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;

  // checks
  // the wrap properties need 2^32 pulses to trigger, so only a formal run reaches them
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_good_inc;
    evt_i.good_byte |=> cnt_reg.good == $past(cnt_reg.good) + 32'h0000_0001;
  endproperty
  a_good_inc: assert property (p_good_inc) else $error("good byte count missed"); // RL1

  property p_undr_inc;
    evt_i.underrun_abort |=> cnt_reg.undr == $past(cnt_reg.undr) + 32'h0000_0001;
  endproperty
  a_undr_inc: assert property (p_undr_inc) else $error("underrun count missed"); // RL2

  property p_total_inc;
    (evt_i.abort || evt_i.underrun_abort) |=>
      cnt_reg.total == $past(cnt_reg.total) + 32'h0000_0001;
  endproperty
  a_total_inc: assert property (p_total_inc) else $error("abort count missed"); // RL3

  property p_no_clear;
    (req && evt_i == 3'h0) |=> $stable(cnt_reg) [*1];
  endproperty
  a_no_clear: assert property (p_no_clear) else $error("bus access moved a counter"); // RL4

  property p_wrap;
    (evt_i.good_byte && cnt_reg.good == `MTSC_CNT_MAX) |=>
      cnt_reg.good == 32'h0000_0000 && sts_reg[`MTSC_IRQ_GOOD_BIT];
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // RL5

  property p_rd_undr;
    (req && !wb_we_i && hit(wb_adr_i, `MTSC_UNDR_ABORT_OFS)) |=>
      wb_ack_o && wb_dat_o[31:24] == $past(cnt_reg.undr[31:24]) && wb_dat_o == $past(cnt_reg.undr);
  endproperty
  a_rd_undr: assert property (p_rd_undr) else $error("underrun read wrong"); // RL6

  property p_rd_total;
    (req && !wb_we_i && hit(wb_adr_i, `MTSC_TOTAL_ABORT_OFS)) |=>
      wb_ack_o && wb_dat_o == $past(cnt_reg.total);
  endproperty
  a_rd_total: assert property (p_rd_total) else $error("abort read wrong"); // RL7

  property p_rd_good_lo;
    (req && !wb_we_i && hit(wb_adr_i, `MTSC_GOOD_BYTE_OFS)) |=>
      wb_dat_o[15:0] == $past(cnt_reg.good[15:0]);
  endproperty
  a_rd_good_lo: assert property (p_rd_good_lo) else $error("good count low half wrong"); // RL8

  property p_rd_good_hi;
    (req && !wb_we_i && hit(wb_adr_i, `MTSC_GOOD_BYTE_OFS)) |=>
      wb_dat_o[31:16] == $past(cnt_reg.good[31:16]);
  endproperty
  a_rd_good_hi: assert property (p_rd_good_hi) else $error("good count high half wrong"); // RL11

  property p_snapshot;
    (req && !wb_we_i) |=> wb_ack_o ##1 (!wb_ack_o && $stable(wb_dat_o));
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("read word not held"); // RL12

  property p_irq;
    irq_o == (|(sts_reg & ena_reg));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  // a wrap of the underrun count also raises its status bit
  property p_undr_wrap;
    (evt_i.underrun_abort && cnt_reg.undr == `MTSC_CNT_MAX) |=>
      cnt_reg.undr == `MTSC_CNT_RST && sts_reg[`MTSC_IRQ_UNDR_BIT];
  endproperty
  a_undr_wrap: assert property (p_undr_wrap) else $error("underrun count did not wrap"); // RL5

  // the total count wraps the same way, whichever pulse drove it
  property p_total_wrap;
    ((evt_i.abort || evt_i.underrun_abort) && cnt_reg.total == `MTSC_CNT_MAX) |=>
      cnt_reg.total == `MTSC_CNT_RST && sts_reg[`MTSC_IRQ_TOTAL_BIT];
  endproperty
  a_total_wrap: assert property (p_total_wrap) else $error("abort count did not wrap"); // RL5

  // the first edge out of reset finds the counters and the answer at rest
  property p_rst_clear;
    $fell(rst_i) |-> cnt_reg == '0 && !wb_ack_o && !irq_o;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("state not clear after reset"); // RL4

  // ack is one cycle wide, so a request still high is not taken twice
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");

  // writes are answered like reads, read-only words included
  property p_wr_ack;
    (req && wb_we_i) |=> wb_ack_o;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write not answered");

  // a status bit stays set until a one is written to its clear bit
  property p_sts_sticky;
    !(wr_stb && hit(wb_adr_i, `MTSC_IRQ_CLEAR_OFS)) |=>
      (sts_reg & $past(sts_reg)) == $past(sts_reg);
  endproperty
  a_sts_sticky: assert property (p_sts_sticky) else $error("status bit lost without a clear");

  // a clear drops its bits unless a wrap lands in the same cycle
  property p_sts_clr;
    (wr_stb && hit(wb_adr_i, `MTSC_IRQ_CLEAR_OFS) && wrap_evt == '0) |=>
      (sts_reg & $past(wb_dat_i[`MTSC_IRQ_W-1:0])) == '0;
  endproperty
  a_sts_clr: assert property (p_sts_clr) else $error("status clear ignored");

  // an enable write lands at the edge that takes it
  property p_ena_wr;
    (wr_stb && hit(wb_adr_i, `MTSC_IRQ_ENABLE_OFS)) |=>
      ena_reg == $past(wb_dat_i[`MTSC_IRQ_W-1:0]);
  endproperty
  a_ena_wr: assert property (p_ena_wr) else $error("enable write lost");

  // main scenarios; the wrap and interrupt ones are for a formal run
  c_rd_undr: cover property (req && !wb_we_i && hit(wb_adr_i, `MTSC_UNDR_ABORT_OFS) ##1 wb_ack_o);
  c_wrap: cover property (evt_i.good_byte && cnt_reg.good == `MTSC_CNT_MAX);
  c_both_abort: cover property (evt_i.abort && evt_i.underrun_abort);
  c_irq: cover property ($rose(irq_o));
  c_rd_busy: cover property (req && !wb_we_i && evt_i.good_byte);

endmodule : mtsc_counters

// ===== bench/mtsc_counters_tb.sv
`timescale 1ns/10ps
module mtsc_counters_tb;
  import mtsc_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e;} mtsc_row_t;
  logic clk_i, rst_i, cyc, stb, we, wb_ack_o, irq_o;
  mtsc_evt_t evt;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, wb_dat_o, q, base;
  int fail_count, n_tests, cyc_cnt, i;
  mtsc_row_t rows [0:13];

  mtsc_counters #(.ADDR_W(12)) uut (.clk_i(clk_i), .rst_i(rst_i), .evt_i(evt), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));

  // 125 mhz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // classic single cycle; ack is sampled with its pre-edge value, so no race with the design
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'h1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  // pulses held back to back for n edges
  task automatic pulse(input mtsc_evt_t e, input int n);
    evt <= e;
    repeat (n) @(posedge clk_i);
    evt <= '0;
    @(posedge clk_i);
  endtask : pulse

  task automatic rd3(input logic [31:0] g, input logic [31:0] u, input logic [31:0] t);
    wb(1'b0, 12'h30C, 32'h0000_0000);
    check(q, g);
    wb(1'b0, 12'h334, 32'h0000_0000);
    check(q, u);
    wb(1'b0, 12'h338, 32'h0000_0000);
    check(q, t);
  endtask : rd3

  // a hang is cut short well above the expected run length
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    rst_i <= 1'b1;
    evt <= '0;
    {cyc, stb, we, adr, sel, dat} <= '0;
    rows[0] = '{1'b0, 12'h30C, 32'h0000_0000, 32'h0000_0005};
    rows[1] = '{1'b0, 12'h334, 32'h0000_0000, 32'h0000_0003};
    rows[2] = '{1'b0, 12'h338, 32'h0000_0000, 32'h0000_0005};
    rows[3] = '{1'b1, 12'h30C, 32'hFFFF_FFFF, 32'h0000_0000};
    rows[4] = '{1'b1, 12'h334, 32'h0000_0000, 32'h0000_0000};
    rows[5] = '{1'b1, 12'h338, 32'hFFFF_FFFF, 32'h0000_0000};
    rows[6] = rows[0];
    rows[7] = rows[1];
    rows[8] = rows[2];
    rows[9] = '{1'b0, 12'h350, 32'h0000_0000, 32'h0000_0000};
    rows[10] = '{1'b1, 12'h348, 32'h0000_0007, 32'h0000_0000};
    rows[11] = '{1'b0, 12'h348, 32'h0000_0000, 32'h0000_0007};
    rows[12] = '{1'b0, 12'h344, 32'h0000_0000, 32'h0000_0000};
    rows[13] = '{1'b0, 12'h340, 32'h0000_0000, 32'h0000_0000};
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd3(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    // underrun alone and with abort both count total once
    pulse(3'h4, 5);
    pulse(3'h2, 2);
    pulse(3'h1, 2);
    pulse(3'h3, 1);
    // counter words ignore writes; writes carry no expectation
    for (i = 0; i < 14; i++) begin
      wb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check(q, rows[i].e);
    end
    check({31'h0000_0000, irq_o}, 32'h0000_0000);
    wb(1'b0, 12'h30E, 32'h0000_0000);
    check({16'h0000, q[15:0]}, 32'h0000_0005);
    // software view: note the start value, count a short interval, subtract modulo two to 32
    base = q;
    evt <= 3'h4;
    wb(1'b0, 12'h30C, 32'h0000_0000);
    check(q, 32'h0000_0005);
    evt <= '0;
    wb(1'b0, 12'h30C, 32'h0000_0000);
    check(q - base, 32'h0000_0003);
    // a reset in mid run is the only thing that clears the counts
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd3(32'h0000_0000, 32'h0000_0000, 32'h0000_0000);
    wb(1'b0, 12'h348, 32'h0000_0000);
    check(q, 32'h0000_0000);
    give_verdict();
  end
endmodule : mtsc_counters_tb
